// >>> hdl/cip_arb_if.sv
`timescale 1ns/1ns
interface cip_arb_if;
    import cip_pkg::*;

    logic [NUM_VEC-1:0] pend;
    logic [VEC_W-1:0] last;
    logic rr_en;
    logic valid;
    logic [VEC_W-1:0] grant;

    modport ctrl (output pend, output last, output rr_en, input valid, input grant);
    modport arb (input pend, input last, input rr_en, output valid, output grant);
endinterface

// >>> hdl/cip_arbiter.sv
`timescale 1ns/1ns
module cip_arbiter (
    // ----------------------------------------------------------------
    // arbitration request and grant
    // ----------------------------------------------------------------
    cip_arb_if.arb arb
);
    import cip_pkg::*;

    logic [NUM_VEC-1:0] above;
    logic [NUM_VEC-1:0] upper;
    logic [NUM_VEC-1:0] sel;
    logic [NUM_VEC-1:0] onehot;

    // vectors strictly above the last acknowledged one
    genvar i;
    generate
        for (i = 0; i < NUM_VEC; i = i + 1) begin : g_above
            assign above[i] = (VEC_W'(i) > arb.last);
        end
    endgenerate

    // (R8) rotate start point
    assign upper = arb.pend & above;
    // (R9) last acknowledged goes to the back of the queue
    assign sel = (arb.rr_en && (|upper)) ? upper : arb.pend;
    // (R7) lowest set bit wins; fixed order when rotation is off
    assign onehot = sel & (~sel + NUM_VEC'(1));
    assign arb.valid = |arb.pend;

    // one-hot to vector number
    always_comb begin
        arb.grant = '0;
        for (int k = 0; k < NUM_VEC; k++) begin
            if (onehot[k]) begin
                arb.grant = arb.grant | VEC_W'(k);
            end
        end
    end
endmodule

// >>> hdl/cip_ctrl.sv
`timescale 1ns/1ns
// Summary of operation
// (R1) placement bit 0: vectors start at application region start
// (R2) placement bit 1: vectors start at boot region start
// (R3) boot region sits first; application start comes from the boot-end fuse
// (R4) placement and compact bits change only while protection unlock is open
// (R5) round-robin bit writable at any time
// (R6) compact bit selects three-entry table; cleared gives full table
// (R7) fixed mode: lowest pending normal-level vector wins
// (R8) round-robin mode: normal-level priority rotates
// (R9) acknowledged normal vector captured, becomes lowest priority next time
// (R10) reset: lowest vector first, last-acknowledged register is zero
// (R11) high-level select register names the one promoted vector
// (R12) select value zero disables the high level
// (R13) non-maskable executing flag set during handler, cleared on its return
// (R14) high-level executing flag holds through non-maskable preemption
// (R15) normal executing flag holds through any preemption
// (R16) compact table: non-maskable at 1, high at 2, normal at 3
// (R17) high level preempts a running normal-level handler
// (R18) non-maskable ignores global enable, never preempted, lowest vector first
// (R19) software unlocks protection then writes within four instructions
// (R20) return clears only the highest active executing flag
module cip_ctrl (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // register bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // peripheral requests and system inputs
    input wire logic [cip_pkg::NUM_VEC-1:0] IRQ_LINES,
    input wire logic [7:0] BOOT_END_FUSE,
    input wire logic CCP_UNLOCK,
    // cpu core
    input wire logic CPU_GIE,
    input wire logic CPU_ACK,
    input wire logic CPU_RETURN_FROM_INTERRUPT,
    output logic IRQ_REQ,
    output cip_pkg::cip_level_type IRQ_LEVEL,
    output logic [cip_pkg::VEC_W-1:0] IRQ_VEC_NUM,
    output logic [cip_pkg::ADDR_W-1:0] IRQ_VEC_ADDR
);
    import cip_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    cip_arb_if arb_if ();
    cip_bus_type bus_r;
    logic [7:0] idx_r;
    logic hit_r;
    logic wr_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic rr_r, cvt_r, vector_placement_select_r;
    logic nonmaskable_executing_r, l1ex_r, l0ex_r;
    logic [7:0] last_r;
    logic [7:0] l1_r;
    logic req_r;
    cip_level_type lvl_r;
    cip_level_type lvl_nxt;
    logic [VEC_W-1:0] vec_r, vec_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic cand_nxt;
    logic wr_stb, wr_ctrl, wr_last, wr_l1;
    logic take;
    logic [7:0] rd_val;
    logic [NUM_VEC-1:0] nmi_pend, nmi_one, l1_mask;
    logic [VEC_W-1:0] nmi_vec;
    logic l1_line;
    logic [15:0] base;
    logic [7:0] slot;

    cip_arbiter u_arb (
        .arb(arb_if.arb)
    );

    // ----------------------------------------------------------------
    // bus slave: one wait state on every access so read data and
    // a write just before it can never race
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            bus_r <= BUS_IDLE;
            idx_r <= 8'h00;
            hit_r <= 1'b0;
            wr_r <= 1'b0;
            hreadyout_r <= 1'b1;
        end else begin
            case (bus_r)
                BUS_IDLE: begin
                    if (HSEL && HREADY && HTRANS[1]) begin
                        bus_r <= BUS_DATA;
                        idx_r <= HADDR[9:2];
                        hit_r <= (HADDR[31:10] == 22'h0) && (HADDR[9:2] < IDX_COUNT);
                        wr_r <= HWRITE;
                        hreadyout_r <= 1'b0;
                    end
                end
                BUS_DATA: begin
                    bus_r <= BUS_IDLE;
                    hreadyout_r <= 1'b1;
                end
                default: begin
                    bus_r <= BUS_IDLE;
                    hreadyout_r <= 1'b1;
                end
            endcase
        end
    end

    // read mux; unmapped and reserved bits read zero
    always_comb begin
        if (!hit_r) begin
            rd_val = 8'h00;
        end else if (idx_r == IDX_CTRL) begin
            rd_val = {1'b0, vector_placement_select_r, cvt_r, 4'h0, rr_r};
        end else if (idx_r == IDX_STATUS) begin
            rd_val = {nonmaskable_executing_r, 5'h00, l1ex_r, l0ex_r};
        end else if (idx_r == IDX_LAST) begin
            rd_val = last_r;
        end else if (idx_r == IDX_L1) begin
            rd_val = l1_r;
        end else begin
            rd_val = 8'h00;
        end
    end

    // read data is loaded in the wait cycle
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            hrdata_r <= 32'h0;
        end else if (bus_r == BUS_DATA && !wr_r) begin
            hrdata_r <= {24'h0, rd_val};
        end
    end

    assign wr_stb = (bus_r == BUS_DATA) && wr_r && hit_r;
    assign wr_ctrl = wr_stb && (idx_r == IDX_CTRL);
    assign wr_last = wr_stb && (idx_r == IDX_LAST);
    assign wr_l1 = wr_stb && (idx_r == IDX_L1);

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rr_r <= RST_CTRL[BIT_RR];
            cvt_r <= RST_CTRL[BIT_CVT];
            vector_placement_select_r <= RST_CTRL[BIT_VECTOR_PLACEMENT_SELECT];
        end else if (wr_ctrl) begin
            // (R5) open bit
            rr_r <= HWDATA[BIT_RR];
            // (R4) protected bits
            if (CCP_UNLOCK) begin
                cvt_r <= HWDATA[BIT_CVT];
                vector_placement_select_r <= HWDATA[BIT_VECTOR_PLACEMENT_SELECT];
            end
        end
    end

    // (R11) promoted vector select
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            l1_r <= RST_L1;
        end else if (wr_l1) begin
            l1_r <= HWDATA[7:0];
        end
    end

    // (R9) (R10) capture acknowledged normal vector in round-robin mode, zero after reset; hardware beats a software write
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            last_r <= RST_LAST;
        end else if (take && lvl_r == LV_L0 && rr_r) begin
            last_r <= vec_r;
        end else if (wr_last) begin
            last_r <= HWDATA[7:0];
        end
    end

    // ----------------------------------------------------------------
    // executing flags
    // ----------------------------------------------------------------
    assign take = CPU_ACK && req_r;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            nonmaskable_executing_r <= 1'b0;
            l1ex_r <= 1'b0;
            l0ex_r <= 1'b0;
        end else begin
            // (R20) only the top active level is retired
            if (CPU_RETURN_FROM_INTERRUPT) begin
                if (nonmaskable_executing_r) begin
                    nonmaskable_executing_r <= 1'b0;
                end else if (l1ex_r) begin
                    l1ex_r <= 1'b0;
                end else begin
                    l0ex_r <= 1'b0;
                end
            end
            // (R13) (R14) (R15) set on entry, kept through preemption; placed last so a set beats a clear
            if (take) begin
                case (lvl_r)
                    LV_NMI: nonmaskable_executing_r <= 1'b1;
                    LV_L1: l1ex_r <= 1'b1;
                    default: l0ex_r <= 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // candidate selection
    // ----------------------------------------------------------------
    assign nmi_pend = IRQ_LINES & NMI_MASK & ~RESET_VEC;
    assign nmi_one = nmi_pend & (~nmi_pend + NUM_VEC'(1));
    // (R12) zero or out-of-range select promotes nothing
    assign l1_line = (l1_r != L1_NONE) && (l1_r < VEC_W'(NUM_VEC)) && IRQ_LINES[l1_r[VIDX_W-1:0]]
        && !NMI_MASK[l1_r[VIDX_W-1:0]];
    assign l1_mask = (l1_r != L1_NONE && l1_r < VEC_W'(NUM_VEC)) ? (NUM_VEC'(1) << l1_r[VIDX_W-1:0]) : '0;
    assign arb_if.pend = IRQ_LINES & ~NMI_MASK & ~l1_mask & ~RESET_VEC;
    assign arb_if.last = last_r;
    assign arb_if.rr_en = rr_r;
    // (R3) application region begins right after the boot region
    assign base = vector_placement_select_r ? BOOT_START : {BOOT_END_FUSE, 8'h00};

    // (R18) static order among non-maskable lines
    always_comb begin
        nmi_vec = '0;
        for (int k = 0; k < NUM_VEC; k++) begin
            if (nmi_one[k]) begin
                nmi_vec = nmi_vec | VEC_W'(k);
            end
        end
    end

    always_comb begin
        cand_nxt = 1'b0;
        lvl_nxt = LV_L0;
        vec_nxt = arb_if.grant;
        slot = cvt_r ? CVT_L0 : arb_if.grant;
        // (R18) no enable needed, nothing enters while a handler of this tier runs
        if ((|nmi_pend) && !nonmaskable_executing_r) begin
            cand_nxt = 1'b1;
            lvl_nxt = LV_NMI;
            vec_nxt = nmi_vec;
            slot = cvt_r ? CVT_NMI : nmi_vec;
        // (R17) high level may enter over a running normal handler
        end else if (CPU_GIE && l1_line && !l1ex_r && !nonmaskable_executing_r) begin
            cand_nxt = 1'b1;
            lvl_nxt = LV_L1;
            vec_nxt = l1_r;
            slot = cvt_r ? CVT_L1 : l1_r;
        end else if (CPU_GIE && arb_if.valid && !l0ex_r && !l1ex_r && !nonmaskable_executing_r) begin
            cand_nxt = 1'b1;
        end
        // (R6) (R16) compact slot or full per-vector slot
        addr_nxt = base + 16'(slot * VEC_WORDS);
    end

    // ----------------------------------------------------------------
    // request to the core, dropped on the acknowledge edge
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            req_r <= 1'b0;
            lvl_r <= LV_L0;
            vec_r <= '0;
            addr_r <= '0;
        end else begin
            req_r <= cand_nxt && !take;
            lvl_r <= lvl_nxt;
            vec_r <= vec_nxt;
            // (R1) (R2) base follows the placement bit
            addr_r <= addr_nxt;
        end
    end

    assign HRDATA = hrdata_r;
    assign HREADYOUT = hreadyout_r;
    assign HRESP = HRESP_OKAY;
    assign IRQ_REQ = req_r;
    assign IRQ_LEVEL = lvl_r;
    assign IRQ_VEC_NUM = vec_r;
    assign IRQ_VEC_ADDR = addr_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    a_protect_guard: assert property (wr_ctrl && !CCP_UNLOCK |=> $stable(vector_placement_select_r) && $stable(cvt_r)) // (R4)
        else $error("protected bit changed without unlock");
    a_rr_open: assert property (wr_ctrl |=> rr_r == $past(HWDATA[BIT_RR])) // (R5)
        else $error("round-robin bit not written");
    a_fixed_lowest: assert property (!rr_r && arb_if.valid |->
        (arb_if.pend & ((NUM_VEC'(1) << arb_if.grant[VIDX_W-1:0]) - NUM_VEC'(1))) == '0) // (R7)
        else $error("fixed order did not pick lowest vector");
    a_rr_rotate: assert property (rr_r && arb_if.pend[last_r[VIDX_W-1:0]] && last_r < VEC_W'(NUM_VEC)
        && $countones(arb_if.pend) > 1 |-> arb_if.grant != last_r) // (R8)
        else $error("last acknowledged vector won again");
    a_rr_capture: assert property (take && lvl_r == LV_L0 && rr_r |=> last_r == $past(vec_r)) // (R9)
        else $error("acknowledged vector not captured");
    a_l1_disabled: assert property (req_r && lvl_r == LV_L1 |-> $past(l1_r) != L1_NONE) // (R12)
        else $error("high level offered while disabled");
    a_nmi_entry: assert property (take && lvl_r == LV_NMI && !CPU_RETURN_FROM_INTERRUPT |=> nonmaskable_executing_r ##1 !req_r) // (R13)
        else $error("non-maskable entry not tracked");
    a_nest_keep: assert property (CPU_RETURN_FROM_INTERRUPT && nonmaskable_executing_r && !take |=> !nonmaskable_executing_r && l1ex_r == $past(l1ex_r)
        && l0ex_r == $past(l0ex_r)) // (R20)
        else $error("return cleared a nested flag");
    a_nmi_block: assert property (nonmaskable_executing_r |=> !req_r) // (R18)
        else $error("request offered during non-maskable handler");
    a_compact_addr: assert property (req_r && lvl_r == LV_L0 && $past(cvt_r) |->
        addr_r == $past(base) + 16'(CVT_L0 * VEC_WORDS)) // (R16)
        else $error("compact normal slot wrong");
    a_bus_wait: assert property (bus_r == BUS_DATA |-> !hreadyout_r ##1 hreadyout_r)
        else $error("bus wait state wrong");

    c_l1_preempt: cover property (l0ex_r && take && lvl_r == LV_L1);
    c_nmi_preempt: cover property (l1ex_r && take && lvl_r == LV_NMI);
    c_rr_grant: cover property (take && rr_r && lvl_r == LV_L0 ##1 req_r && lvl_r == LV_L0);
    c_ccp_write: cover property (wr_ctrl && CCP_UNLOCK);
endmodule

// >>> hdl/cip_pkg.sv
package cip_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_VEC = 32;
    localparam int VIDX_W = 5;
    localparam int VEC_W = 8;
    localparam int ADDR_W = 16;

    // ----------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_LAST = 8'h02;
    localparam logic [7:0] IDX_L1 = 8'h03;
    localparam logic [7:0] IDX_COUNT = 8'h04;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int BIT_RR = 0;
    localparam int BIT_CVT = 5;
    localparam int BIT_VECTOR_PLACEMENT_SELECT = 6;
    localparam int BIT_L0EX = 0;
    localparam int BIT_L1EX = 1;
    localparam int BIT_NONMASKABLE_EXECUTING = 7;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_LAST = 8'h00;
    localparam logic [7:0] RST_L1 = 8'h00;
    localparam logic [7:0] L1_NONE = 8'h00;

    // ----------------------------------------------------------------
    // vector layout
    // ----------------------------------------------------------------
    localparam logic [7:0] CVT_NMI = 8'h01;
    localparam logic [7:0] CVT_L1 = 8'h02;
    localparam logic [7:0] CVT_L0 = 8'h03;
    localparam logic [15:0] VEC_WORDS = 16'h0002;
    localparam logic [15:0] BOOT_START = 16'h0000;
    // which vectors are non-maskable; device dependent, fixed here
    localparam logic [NUM_VEC-1:0] NMI_MASK = 32'h0000_0002;
    // vector 0 is the reset vector and never requests
    localparam logic [NUM_VEC-1:0] RESET_VEC = 32'h0000_0001;

    // ----------------------------------------------------------------
    // bus encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LV_L0 = 3'b001,
        LV_L1 = 3'b010,
        LV_NMI = 3'b100
    } cip_level_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } cip_bus_type;

endpackage

// >>> sim/cip_core_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// core model: takes each offer after a chosen delay, returns on request
// ----------------------------------------------------------------
module cip_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // offer from the controller
    input wire logic irq_req,
    // bench control: acknowledge delay and return request
    input wire logic [1:0] delay,
    input wire logic ret_go,
    // to the controller
    output logic cpu_ack,
    output logic cpu_return_from_interrupt
);
    logic [1:0] wait_r;

    // one acknowledge per offer; a late acknowledge models a core busy with a long instruction
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_ack <= 1'b0;
            wait_r <= 2'h0;
        end else if (cpu_ack || !irq_req) begin
            cpu_ack <= 1'b0;
            wait_r <= 2'h0;
        end else if (wait_r >= delay) begin
            cpu_ack <= 1'b1;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
    end

    // return pulse lasts one cycle, one cycle after the handler asks for it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_return_from_interrupt <= 1'b0;
        end else begin
            cpu_return_from_interrupt <= ret_go;
        end
    end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ns
module tb;
    import cip_pkg::*;

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] irq_lines = 32'h0;
    logic [7:0] fuse = 8'h00;
    logic unlock = 1'b0;
    logic gie = 1'b0;
    logic ret_go = 1'b0;
    logic [1:0] delay = 2'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic cpu_ack;
    logic cpu_return_from_interrupt;
    logic irq_req;
    cip_level_type irq_level;
    logic [7:0] irq_vec;
    logic [15:0] irq_addr;
    logic [31:0] lfsr = 32'hc8a49076;
    int n_mismatch = 0;
    int check_count = 0;

    always #10 clk_sys = ~clk_sys;

    cip_ctrl cip_ctrl_i (.CLK_SYS(clk_sys), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .IRQ_LINES(irq_lines), .BOOT_END_FUSE(fuse),
        .CCP_UNLOCK(unlock), .CPU_GIE(gie), .CPU_ACK(cpu_ack), .CPU_RETURN_FROM_INTERRUPT(cpu_return_from_interrupt), .IRQ_REQ(irq_req),
        .IRQ_LEVEL(irq_level), .IRQ_VEC_NUM(irq_vec), .IRQ_VEC_ADDR(irq_addr));
    cip_core_model cip_core_model_i (.clk(clk_sys), .rstn(rstn), .irq_req(irq_req), .delay(delay),
        .ret_go(ret_go), .cpu_ack(cpu_ack), .cpu_return_from_interrupt(cpu_return_from_interrupt));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0);
    endfunction

    // expected winner: rotating order starts above the last taken vector, then wraps
    function automatic logic [7:0] pick(input logic [31:0] p, input logic rr, input logic [7:0] last);
        for (int i = 0; i < 32; i++)
            if (p[i] && (!rr || i > last))
                return i[7:0];
        for (int i = 0; i < 32; i++)
            if (p[i])
                return i[7:0];
        return 8'h00;
    endfunction

    // expected vector address above the application start: compact slot or the vector's own slot
    function automatic logic [15:0] vaddr(input logic [7:0] fz, input logic compact_table_enable, input logic [7:0] cs,
        input logic [7:0] v);
        return {fz, 8'h00} + 16'(compact_table_enable ? cs : v) * VEC_WORDS;
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one single word transfer; read data is taken at the edge that sees ready again
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 50);
        rd = hrdata;
        chk(32'(hresp), 32'(HRESP_OKAY));
        if (hready !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, idx, d, dummy);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, idx, 32'h0, v);
        chk(v, exp);
    endtask

    // wait for the core to take an offer and compare what was offered at that edge
    task automatic take(input logic [7:0] v, input cip_level_type lv, input logic [15:0] a);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cpu_ack !== 1'b1 && n < 50);
        if (cpu_ack !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        chk(32'(irq_vec), 32'(v));
        chk(32'(irq_level), 32'(lv));
        chk(32'(irq_addr), 32'(a));
    endtask

    task automatic ret();
        ret_go <= 1'b1;
        @(posedge clk_sys);
        ret_go <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] p;
        logic [31:0] ctrl;
        logic [7:0] last;
        logic [7:0] v;
        logic [7:0] f;
        logic [15:0] base;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        // reset values, an unmapped place and the read-only status
        rdc(IDX_CTRL, 32'(RST_CTRL));
        rdc(IDX_STATUS, 32'h0);
        rdc(IDX_LAST, 32'(RST_LAST));
        rdc(IDX_L1, 32'(RST_L1));
        wr(8'h07, 32'hff);
        rdc(8'h07, 32'h0);
        wr(IDX_STATUS, 32'hff);
        rdc(IDX_STATUS, 32'h0);
        // protected bits refused while locked, round-robin bit always taken
        wr(IDX_CTRL, 32'h61);
        rdc(IDX_CTRL, 32'h01);
        unlock <= 1'b1;
        wr(IDX_CTRL, 32'h60);
        unlock <= 1'b0;
        rdc(IDX_CTRL, 32'h60);
        wr(IDX_CTRL, 32'h00);
        rdc(IDX_CTRL, 32'h60);
        // random modes, fuse, core delay and pending sets
        gie <= 1'b1;
        last = 8'h00;
        f = 8'h00;
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_step(lfsr);
            ctrl = {25'h0, lfsr[6:5], 4'h0, lfsr[0]};
            f = lfsr[15:8];
            fuse <= f;
            delay <= lfsr[17:16];
            unlock <= 1'b1;
            wr(IDX_CTRL, ctrl);
            unlock <= 1'b0;
            lfsr = lfsr_step(lfsr);
            p = lfsr & 32'hffff_fffc;
            if (p == 32'h0)
                p = 32'h4;
            v = pick(p, ctrl[0], last);
            base = ctrl[6] ? BOOT_START : {f, 8'h00};
            irq_lines <= p;
            take(v, LV_L0, base + 16'(ctrl[5] ? CVT_L0 : v) * VEC_WORDS);
            irq_lines <= 32'h0;
            if (ctrl[0])
                last = v;
            rdc(IDX_LAST, 32'(last));
            rdc(IDX_STATUS, 32'h01);
            ret();
            rdc(IDX_STATUS, 32'h00);
        end
        // nesting in both table layouts: normal, then promoted vector, then non-maskable with enable off
        for (int c = 0; c < 2; c++) begin
            unlock <= 1'b1;
            wr(IDX_CTRL, c[0] ? 32'h20 : 32'h00);
            unlock <= 1'b0;
            gie <= 1'b1;
            wr(IDX_L1, 32'h09);
            rdc(IDX_L1, 32'h09);
            irq_lines <= 32'h10;
            take(8'h04, LV_L0, vaddr(f, c[0], CVT_L0, 8'h04));
            irq_lines <= 32'h200;
            take(8'h09, LV_L1, vaddr(f, c[0], CVT_L1, 8'h09));
            gie <= 1'b0;
            irq_lines <= 32'h2;
            take(8'h01, LV_NMI, vaddr(f, c[0], CVT_NMI, 8'h01));
            // the non-maskable line stays high but nothing may be offered now
            repeat (4) @(posedge clk_sys);
            chk(32'(irq_req), 32'h0);
            rdc(IDX_STATUS, 32'h83);
            irq_lines <= 32'h0;
            ret();
            rdc(IDX_STATUS, 32'h03);
            ret();
            rdc(IDX_STATUS, 32'h01);
            ret();
            rdc(IDX_STATUS, 32'h00);
            // normal request refused while globally disabled
            irq_lines <= 32'h10;
            repeat (4) @(posedge clk_sys);
            chk(32'(irq_req), 32'h0);
            // zero select: the former promoted vector stays normal
            wr(IDX_L1, 32'h00);
            gie <= 1'b1;
            irq_lines <= 32'h200;
            take(8'h09, LV_L0, vaddr(f, c[0], CVT_L0, 8'h09));
            irq_lines <= 32'h0;
            ret();
        end
        // a second reset in mid-run brings the registers back from non-zero values
        wr(IDX_LAST, 32'h05);
        rdc(IDX_LAST, 32'h05);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        chk(32'(irq_req), 32'h0);
        rdc(IDX_LAST, 32'(RST_LAST));
        rdc(IDX_CTRL, 32'(RST_CTRL));
        end_sim();
    end
endmodule
